// File: verilog/abg_core.sv
/*
 Sequencing, accumulation, justification and indirect gain registers of a
 12-bit converter, with an Avalon-MM register slave.
 Assumes the analog converter returns its code on sar_code, the window
 comparator answers on win_match in the same clock domain, and timer
 overflows arrive as one-cycle pulses on clk.
*/
// How it works
// - Burst enable bit selects burst sequencing
// - Converter powers down between bursts unless enabled
// - Powered-down converter waits power-up delay first
// - Burst timed by own counters, not bus
// - Burst start runs repeat-count conversions
// - Done flag only after full repeat count
// - Window compare only on full accumulated sum
// - Single conversion updates result every time
// - Left-justify bit aligns single 12-bit code
// - Unused result bits read zero
// - Repeat above one gives right-aligned sum
// - Gain held in thirteen bits, three registers
// - Gain equals word over 4096 plus extra over 64
// - Gain resets to unity setting
// - Gain access redirects result byte writes
// - Gain registers cannot be read back
// - Gain addresses decode 0x04, 0x07, 0x08
// - Busy high during conversion, falling at series end sets done
// - Repeat field selects 1, 4, 8, 16
// - Conversion 13 SAR clocks plus two
module abg_core
    import abg_pkg::*;
#(
    parameter int TMR_W        = 16,
    parameter int PWR_STEP_CYC = 16,
    parameter int TK_STEP_CYC  = 4
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ext_start,
    input  wire logic        tmr1_ovf,
    input  wire logic        tmr2_ovf,
    input  wire logic [11:0] sar_code,
    input  wire logic        win_match,
    output logic             conv_power,
    output logic             conv_track,
    output logic             conv_done,
    output logic             win_strobe,
    output logic      [15:0] win_value,
    output logic      [11:0] gain_word,
    output logic             gain_extra
);
    if (TMR_W < 12 || PWR_STEP_CYC < 1 || TK_STEP_CYC < 1 ||
        (16 * PWR_STEP_CYC) >= (1 << TMR_W) || (3 * TK_STEP_CYC + 2) >= (1 << TMR_W)) begin : g_chk
        $error("abg_core: timer too narrow or step counts out of range");
    end

    function automatic logic [3:0] rpt_last(input logic [1:0] f);
        case (f)
            2'h0:    rpt_last = 4'h0;
            2'h1:    rpt_last = 4'h3;
            2'h2:    rpt_last = 4'h7;
            default: rpt_last = 4'hf;
        endcase
    endfunction

    abg_ctrl_t   ctrl_q;
    abg_cfg_t    cfg_q;
    abg_timing_t tim_q;
    abg_state_t  state_q;
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [15:0] result_q;
    logic [15:0] acc_q;
    logic [3:0]  cnt_q;
    logic [TMR_W-1:0] tmr_q;
    logic [7:0]  gain_addr_q;
    logic [7:0]  gain_hi_q;
    logic [3:0]  gain_lo_q;
    logic        gain_ex_q;
    logic [2:0]  ext_sync_q;
    logic [11:0] code_s1_q;
    logic [11:0] code_s2_q;
    logic        power_q;
    logic        track_q;
    logic        win_stb_q;
    logic        pub_q;

    logic        acc_w;
    logic        wr_ctrl;
    logic        wr_cfg;
    logic        wr_hi;
    logic        wr_lo;
    logic        wr_tim;
    abg_ctrl_t   wctrl;
    logic        start;
    logic        pub;
    logic        last;
    logic [15:0] sum;
    logic [15:0] pub_val;
    logic [TMR_W-1:0] pwr_cyc;
    logic [TMR_W-1:0] trk_cyc;
    logic [TMR_W-1:0] cnv_cyc;

    // Bus decode; a write takes effect on the edge that sees waitrequest low
    assign acc_w   = avs_write && !wait_q && avs_byteenable[0];
    assign wr_ctrl = acc_w && (avs_address == ADDR_CTRL);
    assign wr_cfg  = acc_w && (avs_address == ADDR_CFG);
    assign wr_hi   = acc_w && (avs_address == ADDR_RES_HI);
    assign wr_lo   = acc_w && (avs_address == ADDR_RES_LO);
    assign wr_tim  = acc_w && (avs_address == ADDR_TIMING);
    assign wctrl   = abg_ctrl_t'(avs_writedata[7:0]);

    always_comb begin
        case (ctrl_q.start_source_select)
            SRC_SW:   start = wr_ctrl && wctrl.conv_busy;
            SRC_EXT:  start = ext_sync_q[1] && !ext_sync_q[2];
            SRC_TMR1: start = tmr1_ovf;
            default:  start = tmr2_ovf;
        endcase
    end

    // Durations derived from the software settings
    assign pwr_cyc = TMR_W'((32'(tim_q.powerup_delay_field) + 1) * PWR_STEP_CYC);
    assign trk_cyc = TMR_W'(32'(tim_q.track_time_setting) * TK_STEP_CYC + TRACK_EXTRA);
    assign cnv_cyc = TMR_W'((32'(cfg_q.sar_div) + 1) * SAR_CYCLES + CONV_EXTRA);

    assign last = (cnt_q == rpt_last(cfg_q.repeat_count_field));
    assign pub  = (state_q == ST_CONV) && (tmr_q == '0) && last;
    assign sum  = acc_q + {4'h0, code_s2_q};

    always_comb begin
        if (cfg_q.repeat_count_field != 2'h0) begin
            pub_val = sum;
        end else if (ctrl_q.left_justify) begin
            pub_val = {code_s2_q, 4'h0};
        end else begin
            pub_val = {4'h0, code_s2_q};
        end
    end

    // Synchronisers for the start pin and the analog code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_sync_q <= 3'h0;
            code_s1_q  <= 12'h000;
            code_s2_q  <= 12'h000;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_start};
            code_s1_q  <= sar_code;
            code_s2_q  <= code_s1_q;
        end
    end

    // Avalon-MM handshake: one wait state, read data registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
            case (avs_address)
                ADDR_CTRL:   rdata_q <= {24'h000000, ctrl_q};
                ADDR_CFG:    rdata_q <= {24'h000000, cfg_q};
                ADDR_RES_HI: rdata_q <= {24'h000000, result_q[15:8]};
                ADDR_RES_LO: rdata_q <= {24'h000000, result_q[7:0]};
                ADDR_TIMING: rdata_q <= {24'h000000, tim_q};
                default:     rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Configuration and timing registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q <= CFG_RST;
            tim_q <= TIMING_RST;
        end else begin
            if (wr_cfg) begin
                cfg_q <= abg_cfg_t'(avs_writedata[7:0]);
            end
            if (wr_tim) begin
                tim_q <= abg_timing_t'(avs_writedata[7:0]);
            end
        end
    end

    // Control register; hardware sets of the flags win over software clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q.converter_on        <= wctrl.converter_on;
                ctrl_q.burst_enable        <= wctrl.burst_enable;
                ctrl_q.left_justify        <= wctrl.left_justify;
                ctrl_q.start_source_select <= wctrl.start_source_select;
                ctrl_q.conv_done_flag      <= wctrl.conv_done_flag;
                ctrl_q.window_match_flag   <= wctrl.window_match_flag;
            end
            ctrl_q.conv_busy <= (state_q != ST_IDLE) && !pub;
            if (pub) begin
                ctrl_q.conv_done_flag <= 1'b1;
            end
            if (win_stb_q && win_match) begin
                ctrl_q.window_match_flag <= 1'b1;
            end
        end
    end

    // Conversion sequencer, self-timed once started
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            tmr_q   <= '0;
            cnt_q   <= 4'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start && ctrl_q.burst_enable && !ctrl_q.converter_on) begin
                        state_q <= ST_PWRUP;
                        tmr_q   <= pwr_cyc;
                    end else if (start && (ctrl_q.burst_enable || ctrl_q.converter_on)) begin
                        if (!ctrl_q.burst_enable && tim_q.track_mode_select == TM_PRE) begin
                            state_q <= ST_CONV;
                            tmr_q   <= cnv_cyc;
                        end else begin
                            state_q <= ST_TRACK;
                            tmr_q   <= trk_cyc;
                        end
                    end
                end
                ST_PWRUP: begin
                    if (tmr_q == '0) begin
                        state_q <= ST_TRACK;
                        tmr_q   <= trk_cyc;
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                ST_TRACK: begin
                    if (tmr_q == '0) begin
                        state_q <= ST_CONV;
                        tmr_q   <= cnv_cyc;
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                ST_CONV: begin
                    if (tmr_q != '0) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else if (last) begin
                        state_q <= ST_IDLE;
                        cnt_q   <= 4'h0;
                    end else if (ctrl_q.burst_enable) begin
                        state_q <= ST_TRACK;
                        tmr_q   <= trk_cyc;
                        cnt_q   <= cnt_q + 1'b1;
                    end else begin
                        state_q <= ST_IDLE;
                        cnt_q   <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Accumulator; partial sums stay internal until the series ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= 16'h0000;
        end else if (state_q == ST_CONV && tmr_q == '0) begin
            acc_q <= last ? 16'h0000 : sum;
        end
    end

    // Result bytes; writes under gain access never reach them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_q <= 16'h0000;
            pub_q    <= 1'b0;
        end else begin
            pub_q <= pub;
            if (pub) begin
                result_q <= pub_val;
            end else if (wr_hi && !cfg_q.gain_access) begin
                result_q[15:8] <= avs_writedata[7:0];
            end else if (wr_lo && !cfg_q.gain_access) begin
                result_q[7:0] <= avs_writedata[7:0];
            end
        end
    end

    // Indirect, write-only gain registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gain_addr_q <= 8'h00;
            gain_hi_q   <= GAIN_HI_RST;
            gain_lo_q   <= GAIN_LO_RST;
            gain_ex_q   <= GAIN_EXTRA_RST;
        end else if (cfg_q.gain_access) begin
            if (wr_hi) begin
                gain_addr_q <= avs_writedata[7:0];
            end
            if (wr_lo) begin
                case (gain_addr_q)
                    GAIN_ADDR_HI:    gain_hi_q <= avs_writedata[7:0];
                    GAIN_ADDR_LO:    gain_lo_q <= avs_writedata[7:4];
                    GAIN_ADDR_EXTRA: gain_ex_q <= avs_writedata[0];
                    default:         gain_ex_q <= gain_ex_q;
                endcase
            end
        end
    end

    // Analog power, tracking and window strobe outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_q   <= 1'b0;
            track_q   <= 1'b0;
            win_stb_q <= 1'b0;
        end else begin
            power_q <= ctrl_q.converter_on || (state_q != ST_IDLE);
            track_q <= (state_q == ST_TRACK) ||
                       (state_q == ST_IDLE && ctrl_q.converter_on &&
                        tim_q.track_mode_select[1]);
            win_stb_q <= pub;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;
    assign conv_power      = power_q;
    assign conv_track      = track_q;
    assign conv_done       = ctrl_q.conv_done_flag;
    assign win_strobe      = win_stb_q;
    assign win_value       = result_q;
    assign gain_word       = {gain_hi_q, gain_lo_q};
    assign gain_extra      = gain_ex_q;

    a_gain_reset: assert property (@(posedge clk) $fell(rst) |->
        gain_word == 12'hfc0 && gain_extra)
        else $error("gain not at unity after reset");

    a_busy_window: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_TRACK) |=> ctrl_q.conv_busy)
        else $error("busy low during a conversion");

    a_done_count: assert property (@(posedge clk) disable iff (rst)
        $rose(ctrl_q.conv_done_flag) && !$past(wr_ctrl) |->
        $past(last) && $past(state_q) == ST_CONV)
        else $error("done set before repeat count reached");

    a_burst_sleep: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_IDLE && !ctrl_q.converter_on) [*2] |-> !conv_power)
        else $error("converter powered while idle and disabled");

    a_pwrup_entry: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_IDLE && start && ctrl_q.burst_enable && !ctrl_q.converter_on)
        |=> state_q == ST_PWRUP ##1 state_q == ST_PWRUP)
        else $error("power-up wait skipped");

    a_win_full: assert property (@(posedge clk) disable iff (rst)
        win_strobe |-> $past(last) && $past(state_q) == ST_CONV && win_value == $past(pub_val))
        else $error("window compare on partial sum");

    a_left_zero: assert property (@(posedge clk) disable iff (rst)
        pub && cfg_q.repeat_count_field == 2'h0 && ctrl_q.left_justify
        |=> result_q[3:0] == 4'h0 && result_q[15:4] == $past(code_s2_q))
        else $error("left-justified code misplaced");

    a_gain_guard: assert property (@(posedge clk) disable iff (rst)
        wr_lo && cfg_q.gain_access |=> $stable(result_q) || $past(pub))
        else $error("gain write disturbed result");

    a_wait_one: assert property (@(posedge clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not one wait state");

endmodule // abg_core

// File: shared/abg_pkg.sv
/*
 Constants, register layouts and state encoding for the converter control block.
 Assumes a 32-bit Avalon-MM slave port with byte addresses and one clock.
*/
package abg_pkg;
    // Bus byte addresses of the directly mapped registers
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CFG    = 8'h04;
    localparam logic [7:0] ADDR_RES_HI = 8'h08;
    localparam logic [7:0] ADDR_RES_LO = 8'h0c;
    localparam logic [7:0] ADDR_TIMING = 8'h10;

    // Indirect gain register addresses, written through the result high byte
    localparam logic [7:0] GAIN_ADDR_HI    = 8'h04;
    localparam logic [7:0] GAIN_ADDR_LO    = 8'h07;
    localparam logic [7:0] GAIN_ADDR_EXTRA = 8'h08;
    localparam logic [7:0] GAIN_HI_RST     = 8'hfc;
    localparam logic [3:0] GAIN_LO_RST     = 4'h0;
    localparam logic       GAIN_EXTRA_RST  = 1'b1;

    // Start sources and tracking modes
    localparam logic [1:0] SRC_SW   = 2'h0;
    localparam logic [1:0] SRC_EXT  = 2'h1;
    localparam logic [1:0] SRC_TMR1 = 2'h2;
    localparam logic [1:0] SRC_TMR2 = 2'h3;
    localparam logic [1:0] TM_PRE   = 2'h2;

    // Timing figures in converter clock cycles
    localparam int SAR_CYCLES  = 13;
    localparam int CONV_EXTRA  = 2;
    localparam int TRACK_EXTRA = 2;

    typedef struct packed {
        logic       converter_on;
        logic       burst_enable;
        logic       conv_done_flag;
        logic       conv_busy;
        logic       window_match_flag;
        logic       left_justify;
        logic [1:0] start_source_select;
    } abg_ctrl_t;

    typedef struct packed {
        logic [4:0] sar_div;
        logic [1:0] repeat_count_field;
        logic       gain_access;
    } abg_cfg_t;

    typedef struct packed {
        logic [3:0] powerup_delay_field;
        logic [1:0] track_time_setting;
        logic [1:0] track_mode_select;
    } abg_timing_t;

    localparam abg_ctrl_t   CTRL_RST   = 8'h00;
    localparam abg_cfg_t    CFG_RST    = 8'hf8;
    localparam abg_timing_t TIMING_RST = 8'h01;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_PWRUP = 2'h1,
        ST_TRACK = 2'h3,
        ST_CONV  = 2'h2
    } abg_state_t;
endpackage

// File: verif/abg_tb.sv
/*
 Self-checking bench for the converter control block: register reset values,
 burst and normal sequencing, accumulation, justification and gain access.
 Assumes the designer's one-wait-state Avalon-MM slave and a single 50 MHz clock.
*/
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module testbench
    import abg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk;
    logic        rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [11:0] sar_code;
    logic        conv_power;
    logic        conv_track;
    logic        conv_done;
    logic        win_strobe;
    logic [15:0] win_value;
    logic [11:0] gain_word;
    logic        gain_extra;
    logic [3:0]  avs_byteenable;
    logic        ext_start;
    logic        win_match;
    logic [3:0]  be_mask;
    logic [31:0] exp_v;
    logic [31:0] exp_q[$];
    logic [15:0] last;
    logic [15:0] sum;
    logic [11:0] code;
    int          n_mismatch;
    int          num_checks;

    abg_core #(.TMR_W(16), .PWR_STEP_CYC(1), .TK_STEP_CYC(1)) DUT (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_start(ext_start), .tmr1_ovf(1'b0), .tmr2_ovf(1'b0), .sar_code(sar_code),
        .win_match(win_match), .conv_power(conv_power), .conv_track(conv_track),
        .conv_done(conv_done), .win_strobe(win_strobe), .win_value(win_value),
        .gain_word(gain_word), .gain_extra(gain_extra)
    );

    always #10 clk = ~clk;

    task automatic wrap_up();
        if (exp_q.size() != 0) n_mismatch++;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= (4'($urandom) | 4'h1) & be_mask;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) n_mismatch++;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        exp_q.push_back({24'h0, ex});
        bus(1'b0, a, 8'h00);
    endtask

    task automatic wait_res();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (win_strobe !== 1'b1 && n < 2000);
        if (n >= 2000) n_mismatch++;
        @(posedge clk);
    endtask

    // Set mode, then start by software; the result is noted when expected
    task automatic conv(input logic on, input logic bst, input logic lj,
                        input logic note, input logic [15:0] ex);
        bus(1'b1, ADDR_CTRL, {on, bst, 1'b0, 1'b0, 1'b0, lj, SRC_SW});
        if (note) exp_q.push_back({16'h0, ex});
        bus(1'b1, ADDR_CTRL, {on, bst, 1'b0, 1'b1, 1'b0, lj, SRC_SW});
        if (note) wait_res();
        else repeat (40) @(posedge clk);
    endtask

    // Monitor: every read answer and every published result takes the oldest note
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) n_mismatch++;
            else begin
                exp_v = exp_q.pop_front();
                `CHK("readdata", exp_v, avs_readdata)
            end
        end
        if (win_strobe === 1'b1) begin
            if (exp_q.size() == 0) n_mismatch++;
            else begin
                exp_v = exp_q.pop_front();
                `CHK("result", exp_v, {16'h0, win_value})
            end
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        sar_code = 12'h000;
        avs_byteenable = 4'h1;
        ext_start = 1'b0;
        win_match = 1'b0;
        be_mask = 4'hf;
        n_mismatch = 0;
        num_checks = 0;
        void'($urandom(19465));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        `CHK("gain_word", 12'hfc0, gain_word)
        `CHK("gain_extra", 1'b1, gain_extra)
        rd(ADDR_CTRL, CTRL_RST);
        rd(ADDR_CFG, CFG_RST);
        rd(ADDR_TIMING, TIMING_RST);
        rd(8'h14, 8'h00);
        // A write without its low byte enabled is refused
        be_mask = 4'he;
        bus(1'b1, ADDR_TIMING, 8'hff);
        be_mask = 4'hf;
        rd(ADDR_TIMING, TIMING_RST);
        // Burst, converter kept on, every repeat count
        for (int r = 0; r < 4; r++) begin
            code = (r == 3) ? 12'hfff : 12'($urandom_range(0, 4095));
            sar_code <= code;
            bus(1'b1, ADDR_CFG, {5'h00, 2'(r), 1'b0});
            last = 16'(code) * 16'((r == 0) ? 1 : (2 << r));
            conv(1'b1, 1'b1, 1'b0, 1'b1, last);
            `CHK("done", 1'b1, conv_done)
            `CHK("power", 1'b1, conv_power)
        end
        // Burst from powered-down idle state
        code = 12'($urandom_range(0, 4095));
        sar_code <= code;
        bus(1'b1, ADDR_CFG, 8'h02);
        conv(1'b0, 1'b1, 1'b0, 1'b1, 16'(code) * 16'h4);
        repeat (4) @(posedge clk);
        `CHK("power", 1'b0, conv_power)
        // Single conversion, left aligned
        code = 12'($urandom_range(0, 4095));
        sar_code <= code;
        bus(1'b1, ADDR_CFG, 8'h00);
        win_match <= 1'b1;
        conv(1'b1, 1'b0, 1'b1, 1'b1, {code, 4'h0});
        win_match <= 1'b0;
        rd(ADDR_CTRL, 8'hac);
        // Normal mode: four starts before one result
        bus(1'b1, ADDR_CFG, 8'h02);
        sum = 16'h0;
        for (int k = 0; k < 4; k++) begin
            code = 12'($urandom_range(0, 4095));
            sar_code <= code;
            sum = sum + 16'(code);
            conv(1'b1, 1'b0, 1'b0, k == 3, sum);
        end
        last = sum;
        // Indirect gain programming
        bus(1'b1, ADDR_CFG, 8'h03);
        rd(ADDR_RES_HI, last[15:8]);
        bus(1'b1, ADDR_RES_HI, GAIN_ADDR_HI);
        bus(1'b1, ADDR_RES_LO, 8'h6c);
        bus(1'b1, ADDR_RES_HI, GAIN_ADDR_LO);
        bus(1'b1, ADDR_RES_LO, 8'ha0);
        bus(1'b1, ADDR_RES_HI, GAIN_ADDR_EXTRA);
        bus(1'b1, ADDR_RES_LO, 8'h00);
        bus(1'b1, ADDR_RES_HI, 8'h05);
        bus(1'b1, ADDR_RES_LO, 8'hff);
        rd(ADDR_RES_LO, last[7:0]);
        bus(1'b1, ADDR_CFG, 8'h02);
        @(posedge clk);
        `CHK("gain_word", 12'h6ca, gain_word)
        `CHK("gain_extra", 1'b0, gain_extra)
        rd(ADDR_RES_HI, last[15:8]);
        rd(ADDR_RES_LO, last[7:0]);
        // Mid-run reset brings the gain back to unity
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("gain_word", 12'hfc0, gain_word)
        `CHK("gain_extra", 1'b1, gain_extra)
        // External start pin, dual tracking, burst with converter kept on
        code = 12'($urandom_range(0, 4095));
        sar_code <= code;
        bus(1'b1, ADDR_CFG, 8'h00);
        bus(1'b1, ADDR_TIMING, 8'h03);
        bus(1'b1, ADDR_CTRL, {1'b1, 1'b1, 4'h0, SRC_EXT});
        exp_q.push_back({20'h0, code});
        ext_start <= 1'b1;
        repeat (4) @(posedge clk);
        ext_start <= 1'b0;
        wait_res();
        `CHK("track", 1'b1, conv_track)
        `CHK("done", 1'b1, conv_done)
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule // testbench
